// ==== logic/rgbi2c_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module rgbi2c_port
   import rgbi2c_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe,
   output logic      output_enable,
   output logic      power_save_n,
   output logic [3:0] duty_ch0,
   output logic [3:0] duty_ch1,
   output logic [3:0] duty_ch2
);
   typedef enum logic [2:0] {
      RGBI2C_IDLE, RGBI2C_ADDR, RGBI2C_SUB, RGBI2C_DATA, RGBI2C_READ, RGBI2C_ACK, RGBI2C_RACK
   } rgbi2c_state_t;

   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;

   rgbi2c_sync u_scl (.mclk(mclk), .rst(rst), .d(scl_i), .q(scl_s));
   rgbi2c_sync u_sda (.mclk(mclk), .rst(rst), .d(sda_i), .q(sda_s));

   rgbi2c_state_t state;
   rgbi2c_state_t next_state;
   rgbi2c_state_t ret;
   rgbi2c_state_t next_ret;
   rgbi2c_regs_t  regs;
   rgbi2c_regs_t  next_regs;
   logic [7:0]    shreg;
   logic [7:0]    next_shreg;
   logic [2:0]    bitcnt;
   logic [2:0]    next_bitcnt;
   logic [6:0]    sub;
   logic [6:0]    next_sub;
   logic          incr_disable;
   logic          next_incr_disable;
   logic          have_sub;
   logic          next_have_sub;
   logic          rd_second;
   logic          next_rd_second;
   logic          byte_done;
   logic          next_byte_done;
   logic          next_sda_o;
   logic          next_sda_oe;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_c;
   logic          stop_c;

   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_c  = scl_s && scl_d && sda_d && !sda_s;
   assign stop_c   = scl_s && scl_d && !sda_d && sda_s;

   always_comb
   begin
      next_state        = state;
      next_ret          = ret;
      next_regs         = regs;
      next_shreg        = shreg;
      next_bitcnt       = bitcnt;
      next_sub          = sub;
      next_incr_disable = incr_disable;
      next_have_sub     = have_sub;
      next_rd_second    = rd_second;
      next_byte_done    = byte_done;
      next_sda_o        = sda_o;
      next_sda_oe       = sda_oe;
      if (start_c)
      begin
         next_state     = RGBI2C_ADDR;
         next_bitcnt    = 3'h0;
         next_byte_done = 1'b0;
         next_sda_oe = 1'b0;
      end
      else if (stop_c)
      begin
         next_state  = RGBI2C_IDLE;
         next_sda_oe = 1'b0;
      end
      else
      begin
         unique case (state)
            RGBI2C_IDLE:
            begin
               next_sda_oe = 1'b0;
            end
            RGBI2C_ADDR, RGBI2C_SUB, RGBI2C_DATA:
            begin
               if (scl_rise)
               begin
                  next_shreg  = {shreg[6:0], sda_s};
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == RGBI2C_BIT_LAST)
                     next_byte_done = 1'b1;
               end
               // The fall right after START must not be taken for a full byte.
               if (scl_fall && byte_done)
               begin
                  next_byte_done = 1'b0;
                  next_sda_oe = 1'b1;
                  next_sda_o  = 1'b0;
                  next_state  = RGBI2C_ACK;
                  if (state == RGBI2C_ADDR)
                  begin
                     if (shreg[7:1] != RGBI2C_SLAVE_ADDR)
                     begin
                        next_sda_oe = 1'b0;
                        next_state  = RGBI2C_IDLE;
                     end
                     else if (shreg[0])
                     begin
                        next_ret       = RGBI2C_READ;
                        next_rd_second = 1'b0;
                     end
                     else
                     begin
                        next_ret      = RGBI2C_SUB;
                        next_have_sub = 1'b0;
                     end
                  end
                  else if (state == RGBI2C_SUB)
                  begin
                     next_sub          = shreg[6:0];
                     next_incr_disable = shreg[RGBI2C_INCR_BIT];
                     next_have_sub     = 1'b1;
                     next_ret          = RGBI2C_DATA;
                  end
                  else
                  begin
                     unique case (rgbi2c_decode(sub))
                        3'h1: next_regs.duty_ch0 = shreg[3:0];
                        3'h2: next_regs.duty_ch1 = shreg[3:0];
                        3'h3: next_regs.duty_ch2 = shreg[3:0];
                        3'h4:
                        begin
                           next_regs.output_enable = shreg[RGBI2C_EN_BIT];
                           next_regs.power_save_n  = shreg[RGBI2C_PS_BIT];
                        end
                        default: ;
                     endcase
                     next_sub = sub + 7'h01;
                     next_ret = incr_disable ? RGBI2C_SUB : RGBI2C_DATA;
                  end
               end
            end
            RGBI2C_ACK:
            begin
               if (scl_fall)
               begin
                  next_bitcnt = 3'h0;
                  next_state  = ret;
                  next_sda_oe = 1'b0;
                  if (ret == RGBI2C_READ)
                  begin
                     next_shreg  = rd_second
                        ? {regs.duty_ch1, regs.duty_ch0}
                        : {2'h0, regs.output_enable, regs.power_save_n, regs.duty_ch2};
                     next_sda_oe = !next_shreg[7];
                     next_sda_o  = 1'b0;
                  end
               end
            end
            RGBI2C_READ:
            begin
               if (scl_fall)
               begin
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == RGBI2C_BIT_LAST)
                  begin
                     next_sda_oe = 1'b0;
                     next_state  = RGBI2C_RACK;
                  end
                  else
                  begin
                     next_shreg  = {shreg[6:0], 1'b0};
                     next_sda_oe = !shreg[6];
                  end
               end
            end
            RGBI2C_RACK:
            begin
               if (scl_fall)
               begin
                  if (!rd_second)
                  begin
                     next_rd_second = 1'b1;
                     next_ret       = RGBI2C_READ;
                     next_state     = RGBI2C_READ;
                     next_bitcnt    = 3'h0;
                     next_shreg     = {regs.duty_ch1, regs.duty_ch0};
                     next_sda_oe    = !next_shreg[7];
                     next_sda_o     = 1'b0;
                  end
                  else
                     next_state = RGBI2C_IDLE;
               end
            end
         endcase
      end
      if (rst)
      begin
         next_state     = RGBI2C_IDLE;
         next_ret       = RGBI2C_IDLE;
         next_regs      = '{RGBI2C_CTRL_RST[1], RGBI2C_CTRL_RST[0], RGBI2C_DUTY_RST,
                            RGBI2C_DUTY_RST, RGBI2C_DUTY_RST};
         next_shreg     = 8'h00;
         next_bitcnt    = 3'h0;
         next_sub       = 7'h00;
         next_incr_disable = 1'b0;
         next_have_sub  = 1'b0;
         next_rd_second = 1'b0;
         next_byte_done = 1'b0;
         next_sda_o     = 1'b0;
         next_sda_oe    = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      scl_d        <= rst ? 1'b1 : scl_s;
      sda_d        <= rst ? 1'b1 : sda_s;
      state        <= next_state;
      ret          <= next_ret;
      regs         <= next_regs;
      shreg        <= next_shreg;
      bitcnt       <= next_bitcnt;
      sub          <= next_sub;
      incr_disable <= next_incr_disable;
      have_sub     <= next_have_sub;
      rd_second    <= next_rd_second;
      byte_done    <= next_byte_done;
      sda_o        <= next_sda_o;
      sda_oe       <= next_sda_oe;
   end

   always_ff @(posedge mclk)
   begin
      output_enable <= next_regs.output_enable;
      power_save_n  <= next_regs.power_save_n;
      duty_ch0      <= next_regs.duty_ch0;
      duty_ch1      <= next_regs.duty_ch1;
      duty_ch2      <= next_regs.duty_ch2;
   end

   property p_reset_regs;
      @(posedge mclk) rst |=> (duty_ch0 == RGBI2C_DUTY_RST && !output_enable && !power_save_n);
   endproperty
   a_reset_regs: assert property (p_reset_regs) else $error("regs not reset");

   property p_unmapped;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_DATA && rgbi2c_decode(sub) == 3'h0) |=> $stable(regs);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped write changed regs");

   property p_ack_low;
      @(posedge mclk) disable iff (rst) (state == RGBI2C_ACK && ret != RGBI2C_READ
         && !$rose(state == RGBI2C_ACK)) |-> (sda_oe && !sda_o);
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not driven");

   property p_bad_addr;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_ADDR && scl_fall && byte_done && shreg[7:1] != RGBI2C_SLAVE_ADDR
       && !start_c && !stop_c) |=> (state == RGBI2C_IDLE && !sda_oe);
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("foreign address answered");

   property p_read_two;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_RACK && rd_second && scl_fall && !start_c && !stop_c)
      |=> state == RGBI2C_IDLE;
   endproperty
   a_read_two: assert property (p_read_two) else $error("third read byte");

   property p_incr;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_DATA && scl_fall && byte_done && !start_c && !stop_c)
      |=> (sub == $past(sub) + 7'h01 && (ret == RGBI2C_SUB) == incr_disable);
   endproperty
   a_incr: assert property (p_incr) else $error("sub-address not advanced");

   property p_first_byte;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_ACK && ret == RGBI2C_READ && !rd_second && scl_fall && !start_c && !stop_c)
      |=> shreg == {2'h0, regs.output_enable, regs.power_save_n, regs.duty_ch2};
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("first read byte wrong");

   property p_second_byte;
      @(posedge mclk) disable iff (rst)
      (state == RGBI2C_RACK && !rd_second && scl_fall && !start_c && !stop_c)
      |=> shreg == {regs.duty_ch1, regs.duty_ch0};
   endproperty
   a_second_byte: assert property (p_second_byte) else $error("second read byte wrong");

   property p_ctrl_out;
      @(posedge mclk) disable iff (rst)
      1'b1 |=> (output_enable == $past(next_regs.output_enable) && power_save_n == regs.power_save_n);
   endproperty
   a_ctrl_out: assert property (p_ctrl_out) else $error("control outputs stale");

   property p_sub_seen;
      @(posedge mclk) disable iff (rst) (state == RGBI2C_DATA) |-> have_sub;
   endproperty
   a_sub_seen: assert property (p_sub_seen) else $error("data before sub-address");

   c_write: cover property (@(posedge mclk) disable iff (rst) state == RGBI2C_DATA ##1 state == RGBI2C_ACK);
   c_read2: cover property (@(posedge mclk) disable iff (rst) state == RGBI2C_RACK && rd_second);
   c_incr:  cover property (@(posedge mclk) disable iff (rst) state == RGBI2C_DATA && !incr_disable);
endmodule : rgbi2c_port
`default_nettype wire

// ==== include/rgbi2c_pkg.sv ====
// Contract
// - Without auto-increment each data byte follows its own sub-address byte.
// - With auto-increment each further data byte goes to the next sub-address.
// - A read frame returns exactly two bytes, then the master stops.
// - First read byte: enable bit 5, power-save bit 4, channel-2 duty bits 3-0.
// - Second read byte: channel-1 duty bits 7-4, channel-0 duty bits 3-0.
// - Slave address is 1010101; bit 0 of address byte high means read.
// - Sub-address bit 7 high disables increment; low bits pick register 1 to 4.
// - Duty registers hold four bits, reset to zero, upper bits unused.
// - Control bit 1 enables outputs, bit 0 low is power-save, reset zero.
package rgbi2c_pkg;
   localparam logic [6:0] RGBI2C_SLAVE_ADDR = 7'h55;
   localparam logic [6:0] RGBI2C_SUB_CH0    = 7'h01;
   localparam logic [6:0] RGBI2C_SUB_CH1    = 7'h02;
   localparam logic [6:0] RGBI2C_SUB_CH2    = 7'h03;
   localparam logic [6:0] RGBI2C_SUB_CTRL   = 7'h04;
   localparam int         RGBI2C_INCR_BIT   = 7;
   localparam int         RGBI2C_EN_BIT     = 1;
   localparam int         RGBI2C_PS_BIT     = 0;
   localparam logic [3:0] RGBI2C_DUTY_RST   = 4'h0;
   localparam logic [1:0] RGBI2C_CTRL_RST   = 2'h0;
   localparam logic [2:0] RGBI2C_BIT_LAST   = 3'h7;

   typedef struct packed {
      logic       output_enable;
      logic       power_save_n;
      logic [3:0] duty_ch2;
      logic [3:0] duty_ch1;
      logic [3:0] duty_ch0;
   } rgbi2c_regs_t;

   // Maps a sub-address onto a register select, zero when unmapped.
   function automatic logic [2:0] rgbi2c_decode(input logic [6:0] sub);
      if (sub >= RGBI2C_SUB_CH0 && sub <= RGBI2C_SUB_CTRL)
         return sub[2:0];
      return 3'h0;
   endfunction : rgbi2c_decode
endpackage : rgbi2c_pkg

// ==== logic/rgbi2c_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rgbi2c_sync
   import rgbi2c_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb
   begin
      next_meta = d;
      next_q    = meta;
      if (rst)
      begin
         next_meta = 1'b1;
         next_q    = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      meta <= next_meta;
      q    <= next_q;
   end
endmodule : rgbi2c_sync
`default_nettype wire

// ==== tb/rgbi2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module rgbi2c_master
(
   input  wire logic mclk,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_pull
);
   int quarter = 4;

   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic tick;
      repeat (quarter) @(negedge mclk);
   endtask : tick

   // Data changes only while the clock line is low.
   task automatic bit_out(input logic b);
      sda_pull = !b;
      tick;
      scl = 1'b1;
      tick;
      tick;
      scl = 1'b0;
      tick;
   endtask : bit_out

   task automatic bit_in(output logic b);
      sda_pull = 1'b0;
      tick;
      scl = 1'b1;
      tick;
      b = sda;
      tick;
      scl = 1'b0;
      tick;
   endtask : bit_in

   task automatic start;
      sda_pull = 1'b0;
      scl      = 1'b1;
      tick;
      sda_pull = 1'b1;
      tick;
      scl = 1'b0;
      tick;
   endtask : start

   // Every frame ends with a stop condition.
   task automatic stop;
      sda_pull = 1'b1;
      tick;
      scl = 1'b1;
      tick;
      sda_pull = 1'b0;
      tick;
   endtask : stop

   task automatic wbyte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
      bit_in(ack);
   endtask : wbyte

   // The master acknowledges the first read byte and not the second.
   task automatic rbyte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bit_in(v[i]);
      bit_out(last);
   endtask : rbyte
endmodule : rgbi2c_master
`default_nettype wire

// ==== tb/rgbi2c_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rgbi2c_port_tb;
   import rgbi2c_pkg::*;
   logic         mclk, rst, scl, sda_pull, sda_o, sda_oe;
   logic         output_enable, power_save_n;
   logic [3:0]   duty_ch0, duty_ch1, duty_ch2;
   wire          sda = !sda_pull && !(sda_oe && !sda_o);
   rgbi2c_regs_t exp;
   logic [7:0]   fb[$];
   logic [31:0]  v;
   logic [7:0]   s;
   int           errors, n_compared;
   integer       seed = 32'h1079;

   rgbi2c_port rgbi2c_port_i (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .output_enable(output_enable), .power_save_n(power_save_n),
      .duty_ch0(duty_ch0), .duty_ch1(duty_ch1), .duty_ch2(duty_ch2));
   rgbi2c_master rgbi2c_master_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
      n_compared++;
      if (seen !== want)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, want, seen);
      end
   endtask : check

   task automatic summarize;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   function automatic rgbi2c_regs_t apply(rgbi2c_regs_t r, logic [6:0] sub, logic [7:0] d);
      case (sub)
         RGBI2C_SUB_CH0: r.duty_ch0 = d[3:0];
         RGBI2C_SUB_CH1: r.duty_ch1 = d[3:0];
         RGBI2C_SUB_CH2: r.duty_ch2 = d[3:0];
         RGBI2C_SUB_CTRL:
         begin
            r.output_enable = d[RGBI2C_EN_BIT];
            r.power_save_n  = d[RGBI2C_PS_BIT];
         end
         default: ;
      endcase
      return r;
   endfunction : apply

   task automatic check_regs;
      repeat (8) @(negedge mclk);
      check("ctrl", {6'h0, output_enable, power_save_n}, {6'h0, exp[13:12]});
      check("ch0", {4'h0, duty_ch0}, {4'h0, exp.duty_ch0});
      check("ch1", {4'h0, duty_ch1}, {4'h0, exp.duty_ch1});
      check("ch2", {4'h0, duty_ch2}, {4'h0, exp.duty_ch2});
   endtask : check_regs

   task automatic wframe(input logic [6:0] addr);
      logic       ack;
      logic [7:0] sub;
      logic       need_sub;
      need_sub = 1'b1;
      rgbi2c_master_i.start;
      rgbi2c_master_i.wbyte({addr, 1'b0}, ack);
      check("addr_ack", {7'h0, ack}, {7'h0, addr != RGBI2C_SLAVE_ADDR});
      foreach (fb[i])
      begin
         rgbi2c_master_i.wbyte(fb[i], ack);
         if (addr == RGBI2C_SLAVE_ADDR)
            check("byte_ack", {7'h0, ack}, 8'h00);
         if (addr != RGBI2C_SLAVE_ADDR)
            ;
         else if (need_sub)
         begin
            sub      = fb[i];
            need_sub = 1'b0;
         end
         else
         begin
            exp = apply(exp, sub[6:0], fb[i]);
            need_sub = sub[RGBI2C_INCR_BIT];
            sub[6:0] = sub[6:0] + 7'h1;
         end
      end
      rgbi2c_master_i.stop;
      fb.delete();
      check_regs;
   endtask : wframe

   task automatic rframe;
      logic       ack;
      logic [7:0] b1, b2;
      rgbi2c_master_i.start;
      rgbi2c_master_i.wbyte({RGBI2C_SLAVE_ADDR, 1'b1}, ack);
      check("rd_ack", {7'h0, ack}, 8'h00);
      rgbi2c_master_i.rbyte(1'b0, b1);
      rgbi2c_master_i.rbyte(1'b1, b2);
      rgbi2c_master_i.stop;
      check("rd1", {2'h0, b1[5:0]}, {2'h0, exp[13:8]});
      check("rd2", b2, exp[7:0]);
      check("release", {7'h0, sda_oe}, 8'h00);
   endtask : rframe

   initial
   begin
      rst = 1'b1;
      exp = '0;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      check_regs;
      fb = '{8'h84, 8'h03};
      wframe(RGBI2C_SLAVE_ADDR);
      fb = '{8'h81, 8'h05, 8'h82, 8'h0a, 8'h83, 8'h0f};
      wframe(RGBI2C_SLAVE_ADDR);
      rframe;
      fb = '{8'h01, 8'h1c, 8'h2d, 8'h3e, 8'h02, 8'h00};
      wframe(RGBI2C_SLAVE_ADDR);
      rframe;
      fb = '{8'h85, 8'hff, 8'h80, 8'hff, 8'h87, 8'h11};
      wframe(RGBI2C_SLAVE_ADDR);
      repeat (20)
      begin
         v = $random(seed);
         rgbi2c_master_i.quarter = v[0] ? 4 : 6;
         s = {v[5], 4'h0, v[8:6]};
         fb.push_back(s);
         repeat (1 + v[10:9])
         begin
            fb.push_back(8'($random(seed)));
            if (s[7])
            begin
               v = $random(seed);
               s = {v[3], 4'h0, v[2:0]};
               fb.push_back(s);
            end
         end
         v = $random(seed);
         wframe(v[1] ? RGBI2C_SLAVE_ADDR : RGBI2C_SLAVE_ADDR ^ (7'h1 << v[4:2] % 7));
         rframe;
      end
      summarize;
   end

   initial
   begin
      repeat (90000) @(posedge mclk);
      errors++;
      summarize;
   end
endmodule : rgbi2c_port_tb
`default_nettype wire
